/* File: hdl/pmux_pkg.sv */
package pmux_pkg;

  // Register bus geometry and answers.
  localparam int         AXI_ADDR_W   = 4;
  localparam logic [3:0] OFS_FSEL_A   = 4'h0;   // Port A function select.
  localparam logic [3:0] OFS_FSEL_B   = 4'h4;   // Second function select.
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Reset values of the two select registers.
  localparam logic [31:0] RST_FSEL_A  = 32'h3F61_1389;
  // The port C field must come up as the serial-plus-GPIO code, one.
  localparam logic [31:0] RST_FSEL_B  = 32'h001E_AA00;

  // Field positions.
  localparam int TOP_LSB    = 30;  // Two bits, top pin pair.
  localparam int PAIR54_LSB = 8;   // Four bits, port A pins 5 and 4.
  localparam int PORTC_LSB  = 20;  // Two bits, port C pins 8 to 6.

  // Top pin pair codes.
  localparam logic [1:0] TOP_DEBUG    = 2'h0;
  localparam logic [1:0] TOP_DSYS     = 2'h1;
  localparam logic [1:0] TOP_GPIO     = 2'h2;
  localparam logic [1:0] TOP_GPIO_ALT = 2'h3;

  // Port A pins 5 and 4 codes.
  localparam logic [3:0] P54_COEX     = 4'h0;
  localparam logic [3:0] P54_I2C_SLV  = 4'h1;
  localparam logic [3:0] P54_SD_HOST  = 4'h2;
  localparam logic [3:0] P54_SDIO_DEV = 4'h3;
  localparam logic [3:0] P54_UART_FC  = 4'h4;
  localparam logic [3:0] P54_I2C_MST  = 4'h5;
  localparam logic [3:0] P54_UART_DAT = 4'h6;
  localparam logic [3:0] P54_I2S_CLK  = 4'h7;
  localparam logic [3:0] P54_GPIO     = 4'h8;
  localparam logic [3:0] P54_GPIO_ALT = 4'h9;

  // Port C pins 8 to 6 codes.
  localparam logic [1:0] PC_DEBUG       = 2'h0;
  localparam logic [1:0] PC_SERIAL_GPIO = 2'h1;
  localparam logic [1:0] PC_GPIO        = 2'h2;

  // Pad indices.
  localparam int NUM_PINS = 7;
  localparam int PIN_TMS  = 0;
  localparam int PIN_A15  = 1;   // Test clock pin, doubles as port A pin 15.
  localparam int PIN_A4   = 2;
  localparam int PIN_A5   = 3;
  localparam int PIN_C6   = 4;
  localparam int PIN_C7   = 5;
  localparam int PIN_C8   = 6;

  // Signals that peripherals drive toward the pads.
  typedef struct packed {
    logic [1:0]          dsysOut;     // Debug system outputs 1:0.
    logic [3:2]          coex;        // Coexistence 5G signals 3:2.
    logic                i2cSlvSdaLow; // Open drain pull-down requests.
    logic                i2cSlvSclLow;
    logic                i2cMstSdaLow;
    logic                i2cMstSclLow;
    logic                sdHostClk;
    logic                sdHostCmdOut;
    logic                sdHostCmdOe;
    logic                sdioCmdOut;
    logic                sdioCmdOe;
    logic                firstSerialRts;
    logic                firstSerialTxd;
    logic                i2sMclk;
    logic                i2sBclk;
    logic                jtagTdo;
    logic                jtagTdoOe;
    logic                secondSerialTxd;
    logic [NUM_PINS-1:0] gpioOut;
    logic [NUM_PINS-1:0] gpioOe;
  } pmux_to_pads_s;

  // Signals that the pads return to the peripherals.
  typedef struct packed {
    logic                jtagTms;
    logic                jtagTck;
    logic                jtagTdi;
    logic                jtagTrstN;
    logic                i2cSlvSda;
    logic                i2cSlvScl;
    logic                i2cMstSda;
    logic                i2cMstScl;
    logic                sdHostCmd;
    logic                sdioClk;
    logic                sdioCmd;
    logic                firstSerialCts;
    logic                firstSerialRxd;
    logic                secondSerialRxd;
    logic [NUM_PINS-1:0] gpioIn;
  } pmux_from_pads_s;

  // Levels handed to peripheral inputs that no pad is routed to.
  localparam pmux_from_pads_s IDLE_FROM_PADS = '{
    jtagTms: 1'b1, jtagTck: 1'b0, jtagTdi: 1'b1, jtagTrstN: 1'b1,
    i2cSlvSda: 1'b1, i2cSlvScl: 1'b1, i2cMstSda: 1'b1, i2cMstScl: 1'b1,
    sdHostCmd: 1'b1, sdioClk: 1'b0, sdioCmd: 1'b1, firstSerialCts: 1'b1,
    firstSerialRxd: 1'b1, secondSerialRxd: 1'b1, gpioIn: 7'h00
  };

endpackage

/* File: hdl/pmux_pin_sync.sv */
// Three-stage pad synchroniser with agreement filter.
module pmux_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Asynchronous pad levels and filtered result.
  input  wire logic [WIDTH-1:0] rawIn,
  output logic      [WIDTH-1:0] cleanOut
);

  logic [WIDTH-1:0] stage1;  // Metastable stage, read only by stage2.
  logic [WIDTH-1:0] stage2;  // First settled stage.
  logic [WIDTH-1:0] stage3;  // Second settled stage.

  // A bit moves on only when the two settled stages agree, so a one-cycle glitch is dropped.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      cleanOut <= '0;
    end else begin
      stage1 <= rawIn;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          cleanOut[i] <= stage3[i];
        end
      end
    end
  end

endmodule

/* File: hdl/pmux_pin_mux.sv */
// How it works
// - Top field zero routes pins to debug port.
// - Pair field zero carries coexistence bits three, two.
// - Pair value two routes SD host clock, command.
// - Pair value three routes SDIO device clock, command.
// - Pair value four carries first UART flow control.
// - Pair value five routes I2C master, both pins.
// - Pair value six carries first UART data.
// - Pair value seven carries I2S master, bit clocks.
// - Port C value one: second UART plus GPIO.
// - Pair field bits 11:8, resets to three.
// - Port C field bits 21:20, resets to one.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
module pmux_pin_mux
  import pmux_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // AXI4-Lite write address and data.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address and data.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Package pads.
  input  wire logic [NUM_PINS-1:0]   padIn,
  output logic      [NUM_PINS-1:0]   padOut,
  output logic      [NUM_PINS-1:0]   padOe,
  // Peripheral side.
  input  wire pmux_to_pads_s         toPads,
  output pmux_from_pads_s            fromPads
);

  // Select registers, reachable over the bus.
  logic [31:0]           fselA;        // Port A function select.
  logic [31:0]           fselB;        // Second function select.
  // Write channel holding state.
  logic [AXI_ADDR_W-1:0] awAddr;       // Captured write address.
  logic                  awHeld;       // Write address taken, waiting for data.
  logic [31:0]           wData;        // Captured write data.
  logic [3:0]            wStrb;        // Captured byte strobes.
  logic                  wHeld;        // Write data taken, waiting for address.
  // Filtered pad levels.
  logic [NUM_PINS-1:0]   pinLevel;

  // Fields that steer the routing.
  wire logic [1:0] topSel  = fselA[TOP_LSB +: 2];
  wire logic [3:0] pairSel = fselA[PAIR54_LSB +: 4];
  wire logic [1:0] portCSel = fselB[PORTC_LSB +: 2];

  // Write decode: the write fires once both halves are held and no response is pending.
  // Both readies stay low while a response waits, so no second write can slip in
  // between the register update and its acknowledgement.
  wire logic doWrite  = awHeld && wHeld && !s_axi_bvalid;
  wire logic wrHitA   = (awAddr == OFS_FSEL_A);
  wire logic wrHitB   = (awAddr == OFS_FSEL_B);
  wire logic [31:0] strbMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
  wire logic [31:0] next_fselA = (fselA & ~strbMask) | (wData & strbMask);
  wire logic [31:0] next_fselB = (fselB & ~strbMask) | (wData & strbMask);

  // Read decode.
  wire logic        doRead  = s_axi_arvalid && s_axi_arready;
  wire logic        rdHitA  = (s_axi_araddr == OFS_FSEL_A);
  wire logic        rdHitB  = (s_axi_araddr == OFS_FSEL_B);
  wire logic [31:0] rdWord  = rdHitA ? fselA : (rdHitB ? fselB : 32'h0000_0000);
  wire logic [1:0]  rdResp  = (rdHitA || rdHitB) ? RESP_OKAY : RESP_SLVERR;

  // Pads cross into the clock domain before anything looks at them.
  // The filter starts from zero, so a pulled-up pad reads low for a few cycles after reset.
  pmux_pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .rawIn    (padIn),
    .cleanOut (pinLevel)
  );

  // Address and data are taken in either order; each ready drops while its half is held.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld        <= 1'b0;
      awAddr        <= '0;
      wHeld         <= 1'b0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Register store and write response; an unmapped address stores nothing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fselA        <= RST_FSEL_A;
      fselB        <= RST_FSEL_B;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (doWrite) begin
        if (wrHitA) begin
          fselA <= next_fselA;
        end else if (wrHitB) begin
          fselB <= next_fselB;
        end
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrHitA || wrHitB) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, data one cycle after the address is taken.
  // While idle the address ready toggles every cycle; that keeps it to one flop and is
  // legal on this bus, but a master must not expect ready to stay high.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdResp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !doRead;
    end
  end

  // Routing decision, recomputed every cycle from the select fields.
  pmux_from_pads_s       next_fromPads;
  logic [NUM_PINS-1:0]   next_padOut;
  logic [NUM_PINS-1:0]   next_padOe;

  always_comb begin
    // Every pad starts as an input and every peripheral input idles.
    next_padOut          = '0;
    next_padOe           = '0;
    next_fromPads        = IDLE_FROM_PADS;
    // Software can always read the pad levels, whatever the routing.
    next_fromPads.gpioIn = pinLevel;

    // Top pin pair.
    case (topSel)
      TOP_DEBUG: begin
        next_fromPads.jtagTms = pinLevel[PIN_TMS];
        next_fromPads.jtagTck = pinLevel[PIN_A15];
      end
      TOP_DSYS: begin
        next_padOut[PIN_TMS] = toPads.dsysOut[0];
        next_padOe[PIN_TMS]  = 1'b1;
        next_padOut[PIN_A15] = toPads.dsysOut[1];
        next_padOe[PIN_A15]  = 1'b1;
      end
      TOP_GPIO, TOP_GPIO_ALT: begin
        // Only pin 15 becomes GPIO; the mode-select pin stays an unused input.
        next_padOut[PIN_A15] = toPads.gpioOut[PIN_A15];
        next_padOe[PIN_A15]  = toPads.gpioOe[PIN_A15];
      end
      default: begin
        // Every code is decoded above; this only keeps the case complete.
      end
    endcase

    // Port A pins 5 and 4, one code for both.
    case (pairSel)
      P54_COEX: begin
        next_padOut[PIN_A5] = toPads.coex[3];
        next_padOe[PIN_A5]  = 1'b1;
        next_padOut[PIN_A4] = toPads.coex[2];
        next_padOe[PIN_A4]  = 1'b1;
      end
      P54_I2C_SLV: begin
        // Open drain: the pad is driven only while pulled low.
        next_padOe[PIN_A5]      = toPads.i2cSlvSclLow;
        next_padOe[PIN_A4]      = toPads.i2cSlvSdaLow;
        next_fromPads.i2cSlvScl = pinLevel[PIN_A5];
        next_fromPads.i2cSlvSda = pinLevel[PIN_A4];
      end
      P54_SD_HOST: begin
        next_padOut[PIN_A5]     = toPads.sdHostClk;
        next_padOe[PIN_A5]      = 1'b1;
        next_padOut[PIN_A4]     = toPads.sdHostCmdOut;
        next_padOe[PIN_A4]      = toPads.sdHostCmdOe;
        next_fromPads.sdHostCmd = pinLevel[PIN_A4];
      end
      P54_SDIO_DEV: begin
        next_fromPads.sdioClk = pinLevel[PIN_A5];
        next_padOut[PIN_A4]   = toPads.sdioCmdOut;
        next_padOe[PIN_A4]    = toPads.sdioCmdOe;
        next_fromPads.sdioCmd = pinLevel[PIN_A4];
      end
      P54_UART_FC: begin
        next_fromPads.firstSerialCts = pinLevel[PIN_A5];
        next_padOut[PIN_A4]          = toPads.firstSerialRts;
        next_padOe[PIN_A4]     = 1'b1;
      end
      P54_I2C_MST: begin
        next_padOe[PIN_A5]      = toPads.i2cMstSclLow;
        next_padOe[PIN_A4]      = toPads.i2cMstSdaLow;
        next_fromPads.i2cMstScl = pinLevel[PIN_A5];
        next_fromPads.i2cMstSda = pinLevel[PIN_A4];
      end
      P54_UART_DAT: begin
        next_fromPads.firstSerialRxd = pinLevel[PIN_A5];
        next_padOut[PIN_A4]          = toPads.firstSerialTxd;
        next_padOe[PIN_A4]     = 1'b1;
      end
      P54_I2S_CLK: begin
        next_padOut[PIN_A5] = toPads.i2sMclk;
        next_padOe[PIN_A5]  = 1'b1;
        next_padOut[PIN_A4] = toPads.i2sBclk;
        next_padOe[PIN_A4]  = 1'b1;
      end
      P54_GPIO, P54_GPIO_ALT: begin
        next_padOut[PIN_A5] = toPads.gpioOut[PIN_A5];
        next_padOe[PIN_A5]  = toPads.gpioOe[PIN_A5];
        next_padOut[PIN_A4] = toPads.gpioOut[PIN_A4];
        next_padOe[PIN_A4]  = toPads.gpioOe[PIN_A4];
      end
      default: begin
        // Codes ten and up leave both pins as idle inputs.
      end
    endcase

    // Port C pins 8 to 6, one code for all three.
    case (portCSel)
      PC_DEBUG: begin
        next_fromPads.jtagTdi   = pinLevel[PIN_C8];
        next_padOut[PIN_C7]     = toPads.jtagTdo;
        next_padOe[PIN_C7]      = toPads.jtagTdoOe;
        next_fromPads.jtagTrstN = pinLevel[PIN_C6];
      end
      PC_SERIAL_GPIO: begin
        next_padOut[PIN_C8]    = toPads.gpioOut[PIN_C8];
        next_padOe[PIN_C8]     = toPads.gpioOe[PIN_C8];
        next_fromPads.secondSerialRxd = pinLevel[PIN_C7];
        next_padOut[PIN_C6]           = toPads.secondSerialTxd;
        next_padOe[PIN_C6]     = 1'b1;
      end
      PC_GPIO: begin
        for (int i = PIN_C6; i <= PIN_C8; i++) begin
          next_padOut[i] = toPads.gpioOut[i];
          next_padOe[i]  = toPads.gpioOe[i];
        end
      end
      default: begin
        // Code three is undefined and leaves the group idle.
      end
    endcase
  end

  // All routed outputs leave through flip-flops; this costs one cycle of latency
  // on every path but keeps pad drivers glitch free while a select changes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      padOut   <= '0;
      padOe    <= '0;
      fromPads <= IDLE_FROM_PADS;
    end else begin
      padOut   <= next_padOut;
      padOe    <= next_padOe;
      fromPads <= next_fromPads;
    end
  end

endmodule

/* File: bench/pmux_monitor.sv */
// Watches routing at the pads against a shadow of the select registers.
module pmux_monitor
  import pmux_pkg::*;
(
  // Clock and reset.
  input wire logic                  clk,
  input wire logic                  arst_n,
  // Register write channels.
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  // Pads and peripherals.
  input wire logic [NUM_PINS-1:0]   padOut,
  input wire logic [NUM_PINS-1:0]   padOe,
  input wire pmux_to_pads_s         toPads
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [AXI_ADDR_W-1:0] addrQ;  // Address taken, waiting for data.
  logic [31:0]           dataQ;  // Data taken, waiting for address.
  logic [3:0]            strbQ;  // Byte lanes of that data.
  logic                  awQ;    // Address half of a write is in.
  logic                  wQ;     // Data half of a write is in.
  logic [31:0]           regA;   // Shadow of the port A select.
  logic [31:0]           regB;   // Shadow of the second select.
  wire logic [3:0]       sel54 = regA[11:8];
  wire logic [1:0]       selC  = regB[21:20];

  // The shadow commits on the edge after both halves are in, the same edge as the design.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awQ  <= 1'b0;
      wQ   <= 1'b0;
      regA <= RST_FSEL_A;
      regB <= RST_FSEL_B;
    end else if (awQ && wQ) begin
      awQ <= 1'b0;
      wQ  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (strbQ[i] && addrQ == OFS_FSEL_A) regA[8*i+:8] <= dataQ[8*i+:8];
        if (strbQ[i] && addrQ == OFS_FSEL_B) regB[8*i+:8] <= dataQ[8*i+:8];
      end
    end else begin
      // Readies stay low while a write is pending, so no capture races a commit.
      if (s_axi_awvalid && s_axi_awready) awQ <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) addrQ <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wQ <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) dataQ <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) strbQ <= s_axi_wstrb;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_coex_drive: assert property (
    sel54 == P54_COEX |=> &padOe[PIN_A5:PIN_A4]
    && padOut[PIN_A5:PIN_A4] == $past(toPads.coex[3:2])) else $error("coex pins wrong");
  a_sd_host: assert property (
    sel54 == P54_SD_HOST |=> padOe[PIN_A5] && padOut[PIN_A5] == $past(toPads.sdHostClk)
    && padOe[PIN_A4] == $past(toPads.sdHostCmdOe)) else $error("sd host pins wrong");
  a_sdio_device: assert property (
    sel54 == P54_SDIO_DEV |=> !padOe[PIN_A5] && padOe[PIN_A4] == $past(toPads.sdioCmdOe))
    else $error("sdio pins wrong");
  a_uart_flow: assert property (
    sel54 == P54_UART_FC |=> !padOe[PIN_A5] && padOe[PIN_A4]
    && padOut[PIN_A4] == $past(toPads.firstSerialRts)) else $error("flow control pins wrong");
  a_i2c_master: assert property (
    sel54 == P54_I2C_MST |=> (padOe[PIN_A5:PIN_A4] & padOut[PIN_A5:PIN_A4]) == 2'h0
    && padOe[PIN_A5:PIN_A4] == $past({toPads.i2cMstSclLow, toPads.i2cMstSdaLow}))
    else $error("i2c master pins wrong");
  a_uart_data: assert property (
    sel54 == P54_UART_DAT |=> !padOe[PIN_A5] && padOe[PIN_A4]
    && padOut[PIN_A4] == $past(toPads.firstSerialTxd)) else $error("uart data pins wrong");
  a_i2s_clocks: assert property (
    sel54 == P54_I2S_CLK |=> &padOe[PIN_A5:PIN_A4]
    && padOut[PIN_A5:PIN_A4] == $past({toPads.i2sMclk, toPads.i2sBclk}))
    else $error("i2s pins wrong");
  a_port_c_serial: assert property (
    selC == PC_SERIAL_GPIO |=> padOe[PIN_C6] && !padOe[PIN_C7]
    && padOut[PIN_C6] == $past(toPads.secondSerialTxd)
    && padOe[PIN_C8] == $past(toPads.gpioOe[PIN_C8])) else $error("port c pins wrong");
  a_undef_float: assert property (
    sel54 > P54_GPIO_ALT |=> padOe[PIN_A5:PIN_A4] == 2'h0) else $error("undefined code drives");
endmodule

bind pmux_pin_mux pmux_monitor u_pmux_monitor (
  .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .padOut, .padOe, .toPads
);

/* File: bench/pmux_pad_model.sv */
// Board around the pads: weak external drivers and the pad pulls.
module pmux_pad_model
  import pmux_pkg::*;
(
  // On-chip drive toward the pads.
  input  wire logic [NUM_PINS-1:0] padOut,
  input  wire logic [NUM_PINS-1:0] padOe,
  // Board-side drive, through series resistors.
  input  wire logic [NUM_PINS-1:0] extVal,
  input  wire logic [NUM_PINS-1:0] extOe,
  // Resolved pad levels.
  output logic      [NUM_PINS-1:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // The resistors let the chip win a fight, so contention never yields an unknown.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extOe[i]) padIn[i] = extVal[i];
      else padIn[i] = (i == PIN_TMS);  // Released: pull-up on the mode pin, pull-down elsewhere.
    end
  end
endmodule

/* File: bench/tb_top.sv */
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_top
  import pmux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_PINS-1:0] padIn, padOut, padOe;
  logic [NUM_PINS-1:0] extVal = '0, extOe = '0;  // Board-side pad drive.
  pmux_to_pads_s toPads = '0;
  pmux_from_pads_s fromPads;
  int errors = 0;
  int nTests = 0;
  int cycles = 0;

  pmux_pin_mux u_pmux_pin_mux (
    .clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .padIn, .padOut, .padOe, .toPads, .fromPads
  );
  pmux_pad_model u_pmux_pad_model (.padOut, .padOe, .extVal, .extOe, .padIn);

  always #2.5 clk = ~clk;

  // A hang ends the run well past the several hundred cycles the sweep needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Offers address and data together and holds each until its own ready.
  task automatic axiWrite(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic axiRead(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Peripheral inputs for one code in every field; unrouted ones sit idle.
  function automatic pmux_from_pads_s expIn(input logic [3:0] c, input logic [NUM_PINS-1:0] p);
    pmux_from_pads_s e;
    e = IDLE_FROM_PADS;
    e.gpioIn = p;
    if (c[1:0] == TOP_DEBUG) {e.jtagTms, e.jtagTck} = {p[PIN_TMS], p[PIN_A15]};
    if (c[1:0] == PC_DEBUG) {e.jtagTdi, e.jtagTrstN} = {p[PIN_C8], p[PIN_C6]};
    if (c[1:0] == PC_SERIAL_GPIO) e.secondSerialRxd = p[PIN_C7];
    case (c)
      P54_I2C_SLV: {e.i2cSlvScl, e.i2cSlvSda} = p[PIN_A5:PIN_A4];
      P54_SD_HOST: e.sdHostCmd = p[PIN_A4];
      P54_SDIO_DEV: {e.sdioClk, e.sdioCmd} = p[PIN_A5:PIN_A4];
      P54_UART_FC: e.firstSerialCts = p[PIN_A5];
      P54_I2C_MST: {e.i2cMstScl, e.i2cMstSda} = p[PIN_A5:PIN_A4];
      P54_UART_DAT: e.firstSerialRxd = p[PIN_A5];
      default: e.gpioIn = p;
    endcase
    return e;
  endfunction

  initial begin
    logic [31:0] d;
    logic [31:0] wd;
    logic [1:0] r;
    logic [63:0] rnd;
    void'($urandom(26));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    axiRead(OFS_FSEL_A, d, r);
    `CHK(d[11:8], P54_SDIO_DEV)
    axiRead(OFS_FSEL_B, d, r);
    `CHK(d[21:20], PC_SERIAL_GPIO)
    axiRead(4'h8, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
    axiWrite(4'hC, 32'hFFFF_FFFF, 4'hF, r);
    `CHK(r, RESP_SLVERR)
    // Every pair code, with top and port C fields stepping along beside it.
    for (int c = 0; c < 16; c++) begin
      wd = {c[1:0], RST_FSEL_A[29:12], c[3:0], RST_FSEL_A[7:0]};
      axiWrite(OFS_FSEL_A, wd, 4'hF, r);
      axiWrite(OFS_FSEL_B, {RST_FSEL_B[31:22], c[1:0], RST_FSEL_B[19:0]}, 4'hF, r);
      axiRead(OFS_FSEL_A, d, r);
      `CHK(d, wd)
      repeat (4) begin
        rnd = {$urandom, $urandom};
        toPads <= rnd[$bits(pmux_to_pads_s)-1:0];
        extVal <= rnd[NUM_PINS+39:40];
        extOe <= rnd[NUM_PINS+49:50];
        repeat (8) @(posedge clk);
        `CHK(fromPads, expIn(4'(c), padIn))
      end
    end
    // A masked byte lane must leave the pair field alone.
    axiWrite(OFS_FSEL_A, 32'h0000_0000, 4'hD, r);
    axiRead(OFS_FSEL_A, d, r);
    `CHK(d, {16'h0000, wd[15:8], 8'h00})
    // A reset in mid-run brings the selects back.
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    axiRead(OFS_FSEL_A, d, r);
    `CHK(d, RST_FSEL_A)
    axiRead(OFS_FSEL_B, d, r);
    `CHK(d[21:20], PC_SERIAL_GPIO)
    end_of_test();
  end
endmodule
